/* File: wdt_core.sv */
// watchdog timer core: write-once option registers, servicing decode, counter, reset request
// assumes synchronous inputs and a system that resets this block on o_sys_reset
`timescale 1ns/1ps
`default_nettype none
module wdt_core (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // register port
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output var  logic [7:0] o_rdata,
  // system state
  input  wire logic       i_debug_mode,
  input  wire logic       i_stop_mode,
  input  wire logic       i_wdog_reset_seen,
  // outputs
  output var  logic       o_sys_reset,
  output var  logic       o_irq
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [7:0]  opt_one;
    logic [7:0]  opt_two;
    logic        one_locked;
    logic        two_locked;
    logic [7:0]  src;
    logic [17:0] cnt;
    logic        sys_reset;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        irq;
    logic [7:0]  rdata;
    logic        src_loaded;
  } wdt_st_t;
  wdt_st_t st_q, st_d;

  logic tick;
  logic halted;
  logic slow_src;
  logic svc_wr;
  logic opt_first_wr;
  logic [17:0] limit;
  logic [1:0] events;

  function automatic logic [17:0] wdt_limit(input logic clk_sel, input logic tmo_sel);
    logic [17:0] r;
    r = wdt_pkg::CNT_SLOW_SHORT;
    unique case ({clk_sel, tmo_sel})
      2'b00: r = wdt_pkg::CNT_SLOW_SHORT;
      2'b01: r = wdt_pkg::CNT_SLOW_LONG;
      2'b10: r = wdt_pkg::CNT_BUS_SHORT;
      2'b11: r = wdt_pkg::CNT_BUS_LONG;
    endcase
    return r;
  endfunction

  // ************************************************************
  // slow tick source
  // ************************************************************
  // the tick divider restarts with the counter so the first slow count is a full period
  wdt_tick u_tick (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_clear (halted | svc_wr | opt_first_wr),
    .o_tick  (tick)
  );

  assign halted       = i_debug_mode | i_stop_mode;
  assign slow_src     = ~st_q.opt_two[wdt_pkg::BIT_CLOCK_SEL];
  assign svc_wr       = i_wr && (i_addr == wdt_pkg::ADDR_RESET_SOURCE);
  assign opt_first_wr = i_wr && ((i_addr == wdt_pkg::ADDR_SYS_OPT_ONE && !st_q.one_locked) ||
                                 (i_addr == wdt_pkg::ADDR_SYS_OPT_TWO && !st_q.two_locked));
  // the long bus count of 2^18 does not fit 18 bits: the counter overflows at all ones
  assign limit = wdt_limit(~slow_src, st_q.opt_one[wdt_pkg::BIT_TIMEOUT_SEL]);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_d        = st_q;
    st_d.rdata  = wdt_pkg::BYTE_ZERO;
    events      = wdt_pkg::IRQ_ZERO;
    // reset source captured once after release; not writable by software
    if (!st_q.src_loaded) begin
      st_d.src_loaded = 1'b1;
      st_d.src = i_wdog_reset_seen ? (8'h01 << wdt_pkg::BIT_SRC_WDOG)
                                   : (8'h01 << wdt_pkg::BIT_SRC_OTHER);
    end
    // write-once option registers
    if (i_wr && i_addr == wdt_pkg::ADDR_SYS_OPT_ONE && !st_q.one_locked) begin
      st_d.opt_one    = i_wdata;
      st_d.one_locked = 1'b1;
    end
    if (i_wr && i_addr == wdt_pkg::ADDR_SYS_OPT_TWO && !st_q.two_locked) begin
      st_d.opt_two    = i_wdata;
      st_d.two_locked = 1'b1;
    end
    if (i_wr && i_addr == wdt_pkg::ADDR_IRQ_MASK) begin
      st_d.irq_mask = i_wdata[1:0];
    end
    // counter
    if (svc_wr || opt_first_wr) begin
      st_d.cnt = wdt_pkg::CNT_ZERO;
      events[wdt_pkg::BIT_IRQ_SERVICE] = svc_wr;
    end else if (halted) begin
      if (slow_src) begin
        st_d.cnt = wdt_pkg::CNT_ZERO;
      end // else hold
    end else if (st_q.opt_one[wdt_pkg::BIT_ENABLE]) begin
      if (!slow_src || tick) begin
        st_d.cnt = st_q.cnt + wdt_pkg::CNT_ONE;
      end
    end else begin
      st_d.cnt = wdt_pkg::CNT_ZERO;
    end
    // overflow raises the system reset request
    if (st_q.opt_one[wdt_pkg::BIT_ENABLE] && st_q.cnt >= limit && !st_q.sys_reset) begin
      st_d.sys_reset = 1'b1;
      events[wdt_pkg::BIT_IRQ_TIMEOUT] = 1'b1;
    end
    // sticky status: set wins over write-one-to-clear
    if (i_wr && i_addr == wdt_pkg::ADDR_IRQ_STATUS) begin
      st_d.irq_stat = st_q.irq_stat & ~i_wdata[1:0];
    end
    st_d.irq_stat = st_d.irq_stat | events;
    st_d.irq      = |(st_d.irq_stat & st_d.irq_mask);
    // read data, one cycle after the strobe
    if (i_rd) begin
      unique case (i_addr)
        wdt_pkg::ADDR_RESET_SOURCE: st_d.rdata = st_q.src;
        wdt_pkg::ADDR_SYS_OPT_ONE:  st_d.rdata = st_q.opt_one;
        wdt_pkg::ADDR_SYS_OPT_TWO:  st_d.rdata = st_q.opt_two;
        wdt_pkg::ADDR_IRQ_STATUS:   st_d.rdata = {6'h00, st_q.irq_stat};
        wdt_pkg::ADDR_IRQ_MASK:     st_d.rdata = {6'h00, st_q.irq_mask};
        default:                    st_d.rdata = wdt_pkg::BYTE_ZERO;
      endcase
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q         <= '0;
      st_q.opt_one <= wdt_pkg::OPT_ONE_RESET;
      st_q.opt_two <= wdt_pkg::OPT_TWO_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_rdata     = st_q.rdata;
  assign o_sys_reset = st_q.sys_reset;
  assign o_irq       = st_q.irq;

  // ************************************************************
  // checks
  // ************************************************************
  service_clears_a: assert property (@(posedge i_clk) disable iff (i_rst)
    svc_wr |=> st_q.cnt == wdt_pkg::CNT_ZERO)
    else $error("service write did not clear counter");
  src_readonly_a: assert property (@(posedge i_clk) disable iff (i_rst)
    st_q.src_loaded && svc_wr |=> st_q.src == $past(st_q.src))
    else $error("service write altered reset source");
  disabled_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !st_q.opt_one[wdt_pkg::BIT_ENABLE] && !st_q.sys_reset |=> !st_q.sys_reset)
    else $error("timeout reset while disabled");
  overflow_reset_a: assert property (@(posedge i_clk) disable iff (i_rst)
    st_q.opt_one[wdt_pkg::BIT_ENABLE] && st_q.cnt >= limit |=> st_q.sys_reset)
    else $error("overflow did not request reset");
  write_once_a: assert property (@(posedge i_clk) disable iff (i_rst)
    st_q.one_locked |=> st_q.opt_one == $past(st_q.opt_one))
    else $error("locked option register changed");
  first_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    opt_first_wr |=> st_q.cnt == wdt_pkg::CNT_ZERO)
    else $error("first option write did not clear counter");
  bus_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    halted && !slow_src && !svc_wr && !opt_first_wr |=> st_q.cnt == $past(st_q.cnt))
    else $error("counter moved while halted on bus clock");
  slow_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
    halted && slow_src ##1 halted |-> st_q.cnt == wdt_pkg::CNT_ZERO)
    else $error("slow counter not zero while halted");
  reset_default_a: assert property (@(posedge i_clk)
    $fell(i_rst) |-> st_q.opt_one[wdt_pkg::BIT_ENABLE] && slow_src)
    else $error("watchdog not enabled after reset");
endmodule // wdt_core
`default_nettype wire

/* File: wdt_core_tb.sv */
// self-checking testbench for the watchdog timer core
// assumes wdt_core and wdt_pkg are compiled first; 50 MHz clock, bus source for short runs
`timescale 1ns/1ps
`default_nettype none
module wdt_core_tb;
  logic       i_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic       i_debug_mode = 1'b0;
  logic       i_stop_mode = 1'b0;
  logic       i_wdog_reset_seen = 1'b0;
  logic       o_sys_reset;
  logic       o_irq;
  int         err_count = 0;
  int         num_checks = 0;

  always #10 i_clk = ~i_clk;

  wdt_core u_wdt_core (
    .i_clk             (i_clk),
    .i_rst             (i_rst),
    .i_addr            (i_addr),
    .i_wdata           (i_wdata),
    .i_wr              (i_wr),
    .i_rd              (i_rd),
    .o_rdata           (o_rdata),
    .i_debug_mode      (i_debug_mode),
    .i_stop_mode       (i_stop_mode),
    .i_wdog_reset_seen (i_wdog_reset_seen),
    .o_sys_reset       (o_sys_reset),
    .o_irq             (o_irq)
  );

  // ****************************************
  // access and compare tasks
  // ****************************************
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1;
    cmp_byte(o_rdata, exp);
  endtask

  task automatic idle_chk(input int n, input logic exp_rst);
    repeat (n) @(posedge i_clk);
    #1;
    cmp_bit(o_sys_reset, exp_rst);
  endtask

  // bounded wait for the watchdog to demand a system reset
  task automatic wait_rst(input int n);
    int k;
    k = 0;
    while (o_sys_reset !== 1'b1 && k < n) begin
      @(posedge i_clk);
      #1;
      k++;
    end
    cmp_bit(o_sys_reset, 1'b1);
  endtask

  task automatic do_reset(input logic seen);
    @(posedge i_clk);
    i_rst             <= 1'b1;
    i_wdog_reset_seen <= seen;
    repeat (6) @(posedge i_clk);
    i_rst             <= 1'b0;
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge i_clk);
    err_count++;
    $display("mismatch at %0t: run did not complete", $time);
    final_report();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    do_reset(1'b0);
    rd(wdt_pkg::ADDR_SYS_OPT_ONE, 8'hc0);
    rd(wdt_pkg::ADDR_SYS_OPT_TWO, 8'h00);
    rd(wdt_pkg::ADDR_RESET_SOURCE, 8'h01);
    rd(4'hf, 8'h00);
    wr(wdt_pkg::ADDR_SYS_OPT_TWO, 8'h40);
    idle_chk(5000, 1'b0);
    wr(wdt_pkg::ADDR_SYS_OPT_ONE, 8'h80);
    idle_chk(5000, 1'b0);
    wr(wdt_pkg::ADDR_SYS_OPT_ONE, 8'h40);
    rd(wdt_pkg::ADDR_SYS_OPT_ONE, 8'h80);
    wr(wdt_pkg::ADDR_IRQ_MASK, 8'h02);
    wr(wdt_pkg::ADDR_RESET_SOURCE, 8'ha5);
    idle_chk(2, 1'b0);
    cmp_bit(o_irq, 1'b1);
    wr(wdt_pkg::ADDR_IRQ_STATUS, 8'h02);
    idle_chk(2, 1'b0);
    cmp_bit(o_irq, 1'b0);
    rd(wdt_pkg::ADDR_IRQ_STATUS, 8'h00);
    rd(wdt_pkg::ADDR_RESET_SOURCE, 8'h01);
    idle_chk(8100, 1'b0);
    wait_rst(300);
    rd(wdt_pkg::ADDR_IRQ_STATUS, 8'h01);
    cmp_bit(o_irq, 1'b0);
    wr(wdt_pkg::ADDR_IRQ_MASK, 8'h01);
    idle_chk(2, 1'b1);
    cmp_bit(o_irq, 1'b1);
    // second reset: the watchdog was the cause this time
    do_reset(1'b1);
    rd(wdt_pkg::ADDR_RESET_SOURCE, 8'h20);
    rd(wdt_pkg::ADDR_SYS_OPT_ONE, 8'hc0);
    wr(wdt_pkg::ADDR_SYS_OPT_TWO, 8'h40);
    wr(wdt_pkg::ADDR_SYS_OPT_ONE, 8'h80);
    idle_chk(4000, 1'b0);
    i_debug_mode <= 1'b1;
    idle_chk(3000, 1'b0);
    i_debug_mode <= 1'b0;
    i_stop_mode  <= 1'b1;
    idle_chk(3000, 1'b0);
    i_stop_mode  <= 1'b0;
    idle_chk(4000, 1'b0);
    wait_rst(400);
    // slow default source, then a disabled watchdog on the bus clock
    do_reset(1'b0);
    idle_chk(4000, 1'b0);
    i_debug_mode <= 1'b1;
    idle_chk(10, 1'b0);
    i_debug_mode <= 1'b0;
    idle_chk(4990, 1'b0);
    wr(wdt_pkg::ADDR_SYS_OPT_TWO, 8'h40);
    wr(wdt_pkg::ADDR_SYS_OPT_ONE, 8'h00);
    idle_chk(9000, 1'b0);
    final_report();
  end
endmodule // wdt_core_tb
`default_nettype wire

/* File: wdt_pkg.sv */
// package for the watchdog timer: register offsets, field positions, reset values, counts
// assumes a plain register port with 8-bit data
package wdt_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] ADDR_RESET_SOURCE = 4'h0;
  localparam logic [3:0] ADDR_SYS_OPT_ONE  = 4'h1;
  localparam logic [3:0] ADDR_SYS_OPT_TWO  = 4'h2;
  localparam logic [3:0] ADDR_IRQ_STATUS   = 4'h3;
  localparam logic [3:0] ADDR_IRQ_MASK     = 4'h4;
  // field positions
  localparam int BIT_ENABLE      = 7;   // system_options_one
  localparam int BIT_TIMEOUT_SEL = 6;   // system_options_one
  localparam int BIT_CLOCK_SEL   = 6;   // system_options_two
  localparam int BIT_SRC_WDOG    = 5;   // reset_source_register
  localparam int BIT_SRC_OTHER   = 0;   // reset_source_register
  localparam int BIT_IRQ_TIMEOUT = 0;   // timeout event
  localparam int BIT_IRQ_SERVICE = 1;   // service event
  // reset values
  localparam logic [7:0] OPT_ONE_RESET = 8'hc0;
  localparam logic [7:0] OPT_TWO_RESET = 8'h00;
  // overflow counts
  localparam logic [17:0] CNT_SLOW_SHORT = 18'h00020;
  localparam logic [17:0] CNT_SLOW_LONG  = 18'h00100;
  localparam logic [17:0] CNT_BUS_SHORT  = 18'h02000;
  // 2^18 does not fit the 18-bit counter: the long bus count stops one short, at all ones
  localparam logic [17:0] CNT_BUS_LONG   = 18'h3ffff;
  localparam logic [17:0] CNT_ZERO       = 18'h00000;
  localparam logic [17:0] CNT_ONE        = 18'h00001;
  // slow tick: 1 ms at 50 MHz
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int CLK_PERIOD_NS  = 20;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
  localparam logic [15:0] TICK_ZERO = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [1:0]  IRQ_ZERO  = 2'h0;
endpackage

/* File: wdt_tick.sv */
// slow tick generator: one-cycle pulse about every millisecond
// assumes a 50 MHz clock; held at zero while i_clear is high
`timescale 1ns/1ps
`default_nettype none
module wdt_tick #(
  parameter logic [15:0] LAST = wdt_pkg::TICK_LAST
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // control
  input  wire logic i_clear,
  output var  logic o_tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } wdt_tick_st_t;
  wdt_tick_st_t st_q, st_d;

  always_comb begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (i_clear) begin
      st_d.cnt = wdt_pkg::TICK_ZERO;
    end else if (st_q.cnt == LAST) begin
      st_d.cnt  = wdt_pkg::TICK_ZERO;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_tick = st_q.tick;
endmodule // wdt_tick
`default_nettype wire
